// [include/irs_pkg.sv]
// Constants, address map and types of the indirect readback and sync strobe block
// How it works
// [RL1] Any sync strobe write pulses sync-out one clock
// [RL2] Sync-out may reach sync-in through two stages
// [RL3] Thirty-two five-bit channel/type read order locations
// [RL4] Types 000-011 select I and Q halves
// [RL5] Types 100-111 select magnitude, phase, gain
// [RL6] Host writes indirect read address at direct 3
// [RL7] Strobe sources fetch anew on each address write
// [RL8] Unstrobed sources read live at direct 0/1
// [RL9] Gain-loop value sampled only by indirect write
// [RL10] Channel nibble valid only 0 to 3, F
// [RL11] Carrier, wait and timing words per channel
// [RL12] Instruction and pointer memories read per channel
// [RL13] Coefficient memories read per channel at ranges
// [RL14] Global F806 returns level detector output
// [RL15] Reset at once, release on fourth edge
package irs_pkg;

    // ------------------------------------------------------------
    // Direct host port addresses
    // ------------------------------------------------------------
    localparam logic [2:0] DIR_DATA_LO = 3'h0;
    localparam logic [2:0] DIR_DATA_HI = 3'h1;
    localparam logic [2:0] DIR_WR_ADDR = 3'h2;
    localparam logic [2:0] DIR_RD_ADDR = 3'h3;

    // ------------------------------------------------------------
    // Global and per-channel indirect locations
    // ------------------------------------------------------------
    localparam logic [15:0] GLB_SYNC_STROBE  = 16'hF809;
    localparam logic [15:0] GLB_ORDER_FIRST  = 16'hF820;
    localparam logic [15:0] GLB_ORDER_LAST   = 16'hF83F;
    localparam logic [15:0] GLB_LEVEL_OUT    = 16'hF806;
    localparam logic [3:0]  NIB_GLOBAL       = 4'hF;
    localparam logic [3:0]  NIB_LAST_CHAN    = 4'h3;
    localparam logic [11:0] OFS_CARRIER      = 12'h006;
    localparam logic [11:0] OFS_TIMING_HI    = 12'h009;
    localparam logic [11:0] OFS_WAIT_DECR    = 12'h00C;
    localparam logic [11:0] OFS_GAIN         = 12'h00F;
    localparam logic [11:0] OFS_INSTR_FIRST  = 12'h100;
    localparam logic [11:0] OFS_INSTR_LAST   = 12'h17F;
    localparam logic [11:0] OFS_PTR_FIRST    = 12'h180;
    localparam logic [11:0] OFS_PTR_LAST     = 12'h1FC;
    localparam logic [11:0] OFS_HBF_FIRST    = 12'h400;
    localparam logic [11:0] OFS_HBF_LAST     = 12'h43F;
    localparam logic [11:0] OFS_CRAM1_FIRST  = 12'h440;
    localparam logic [11:0] OFS_CRAM1_LAST   = 12'h47F;
    localparam logic [11:0] OFS_CRAM2_FIRST  = 12'h480;
    localparam logic [11:0] OFS_CRAM2_LAST   = 12'h4FF;
    localparam logic [11:0] OFS_RESAMP_FIRST = 12'h500;
    localparam logic [11:0] OFS_RESAMP_LAST  = 12'h5FF;

    // ------------------------------------------------------------
    // Read order selector fields and data type codes
    // ------------------------------------------------------------
    localparam int          ORDER_DEPTH  = 32;
    localparam int          SEL_W        = 5;
    localparam int          TYPE_W       = 3;
    localparam logic [4:0]  ORDER_RESET  = 5'h00;
    localparam logic [2:0]  TYPE_I_HI    = 3'h0;
    localparam logic [2:0]  TYPE_I_LO    = 3'h1;
    localparam logic [2:0]  TYPE_Q_HI    = 3'h2;
    localparam logic [2:0]  TYPE_Q_LO    = 3'h3;
    localparam logic [2:0]  TYPE_MAG_HI  = 3'h4;
    localparam logic [2:0]  TYPE_MAG_LO  = 3'h5;
    localparam logic [2:0]  TYPE_PHASE   = 3'h6;
    localparam logic [2:0]  TYPE_GAIN    = 3'h7;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int          NUM_CHAN     = 4;
    localparam int          PATH_W       = 24;
    localparam int          WORD_W       = 32;
    localparam int          RESET_EDGES  = 4;

    typedef enum logic [2:0] {
        K_NONE, K_CARRIER, K_TIMING, K_WAIT, K_GAIN, K_MEM, K_LEVEL, K_ORDER
    } irs_kind_t;

endpackage

// [src/irs_order_mux.sv]
// Read order selector: picks one 16-bit word from a channel's datapath outputs
module irs_order_mux (
    input  wire logic [4:0]  sel,
    input  wire logic [95:0] i_data,
    input  wire logic [95:0] q_data,
    input  wire logic [95:0] mag_data,
    input  wire logic [63:0] phase_data,
    input  wire logic [63:0] gain_data,
    output logic      [15:0] word
);
    logic [1:0]  chan;
    logic [2:0]  dtype;
    logic [23:0] i_w;
    logic [23:0] q_w;
    logic [23:0] m_w;

    // ------------------------------------------------------------
    // Channel number sits above the data type code
    // ------------------------------------------------------------
    assign chan  = sel[4:3]; // RL3
    assign dtype = sel[2:0]; // RL3
    assign i_w   = i_data[24*chan +: 24];
    assign q_w   = q_data[24*chan +: 24];
    assign m_w   = mag_data[24*chan +: 24];

    always_comb begin
        case (dtype)
            irs_pkg::TYPE_I_HI:   word = i_w[23:8]; // RL4
            irs_pkg::TYPE_I_LO:   word = {i_w[7:0], 8'h00}; // RL4
            irs_pkg::TYPE_Q_HI:   word = q_w[23:8]; // RL4
            irs_pkg::TYPE_Q_LO:   word = {q_w[7:0], 8'h00}; // RL4
            irs_pkg::TYPE_MAG_HI: word = m_w[23:8]; // RL5
            irs_pkg::TYPE_MAG_LO: word = {m_w[7:0], 8'h00}; // RL5
            irs_pkg::TYPE_PHASE:  word = phase_data[16*chan +: 16]; // RL5
            irs_pkg::TYPE_GAIN:   word = gain_data[16*chan +: 16]; // RL5
            default:              word = 16'h0000;
        endcase
    end

endmodule // irs_order_mux

// [src/irs_host_port.sv]
// Host port readback, indirect read select, sync-out strobe and FIFO read order
module irs_host_port (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce_n,
    input  wire logic         wr_n,
    input  wire logic         rd_n,
    input  wire logic [2:0]   addr,
    input  wire logic [15:0]  p_in,
    output logic      [15:0]  p_out,
    output logic              p_oe,
    output logic              sync_out_pin,
    input  wire logic [127:0] carrier_freq_in,
    input  wire logic [127:0] timing_freq_in,
    input  wire logic [127:0] wait_decr_in,
    input  wire logic [63:0]  gain_loop_in,
    input  wire logic [31:0]  level_acc_in,
    output logic              level_stab_stb,
    output logic [15:0]       mem_rd_addr,
    output logic              mem_fetch_stb,
    input  wire logic [31:0]  mem_rd_data,
    input  wire logic [95:0]  i_data,
    input  wire logic [95:0]  q_data,
    input  wire logic [95:0]  mag_data,
    input  wire logic [63:0]  phase_data,
    input  wire logic         fifo_rd_stb,
    output logic [15:0]       fifo_word
);
    // ------------------------------------------------------------
    // Internal reset: drops at once, rises on the fourth edge
    // ------------------------------------------------------------
    logic [irs_pkg::RESET_EDGES-1:0] rst_sr_reg;
    logic                            core_rst_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sr_reg <= '0; // RL15
        end else begin
            rst_sr_reg <= {rst_sr_reg[irs_pkg::RESET_EDGES-2:0], 1'b1}; // RL15
        end
    end
    assign core_rst_n = rst_sr_reg[irs_pkg::RESET_EDGES-1];

    // ------------------------------------------------------------
    // Pin synchronisers, two stages each
    // ------------------------------------------------------------
    logic [21:0] pin_s1_reg;
    logic [21:0] pin_s2_reg;
    logic        ce_s_n;
    logic        wr_s_n;
    logic        rd_s_n;
    logic [2:0]  addr_s;
    logic [15:0] p_s;

    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pin_s1_reg <= 22'h3FFFFF;
            pin_s2_reg <= 22'h3FFFFF;
        end else begin
            pin_s1_reg <= {ce_n, wr_n, rd_n, addr, p_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign {ce_s_n, wr_s_n, rd_s_n, addr_s, p_s} = pin_s2_reg;

    // ------------------------------------------------------------
    // Address decode, used for strobes and for the read mux
    // ------------------------------------------------------------
    function automatic irs_pkg::irs_kind_t decode(input logic [15:0] a);
        logic [11:0] o;
        o = a[11:0];
        decode = irs_pkg::K_NONE;
        if (a == irs_pkg::GLB_LEVEL_OUT) begin
            decode = irs_pkg::K_LEVEL; // RL14
        end else if (a >= irs_pkg::GLB_ORDER_FIRST && a <= irs_pkg::GLB_ORDER_LAST) begin
            decode = irs_pkg::K_ORDER; // RL3
        end else if (a[15:12] <= irs_pkg::NIB_LAST_CHAN) begin // RL10
            if (o == irs_pkg::OFS_CARRIER) begin
                decode = irs_pkg::K_CARRIER; // RL11
            end else if (o == irs_pkg::OFS_TIMING_HI) begin
                decode = irs_pkg::K_TIMING; // RL11
            end else if (o == irs_pkg::OFS_WAIT_DECR) begin
                decode = irs_pkg::K_WAIT; // RL11
            end else if (o == irs_pkg::OFS_GAIN) begin
                decode = irs_pkg::K_GAIN; // RL9
            end else if ((o >= irs_pkg::OFS_INSTR_FIRST && o <= irs_pkg::OFS_INSTR_LAST)
                      || (o >= irs_pkg::OFS_PTR_FIRST && o <= irs_pkg::OFS_PTR_LAST)) begin
                decode = irs_pkg::K_MEM; // RL12
            end else if ((o >= irs_pkg::OFS_HBF_FIRST && o <= irs_pkg::OFS_HBF_LAST)
                      || (o >= irs_pkg::OFS_CRAM1_FIRST && o <= irs_pkg::OFS_CRAM1_LAST)
                      || (o >= irs_pkg::OFS_CRAM2_FIRST && o <= irs_pkg::OFS_CRAM2_LAST)
                      || (o >= irs_pkg::OFS_RESAMP_FIRST && o <= irs_pkg::OFS_RESAMP_LAST)) begin
                decode = irs_pkg::K_MEM; // RL13
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Host write capture and register state
    // ------------------------------------------------------------
    logic              wr_prev_reg,  wr_prev_next;
    logic              lat_ce_reg,   lat_ce_next;
    logic [2:0]        lat_a_reg,    lat_a_next;
    logic [15:0]       lat_d_reg,    lat_d_next;
    logic [15:0]       wdat_lo_reg,  wdat_lo_next;
    logic [15:0]       wdat_hi_reg,  wdat_hi_next;
    logic [15:0]       ira_reg,      ira_next;
    logic              sync_reg,     sync_next;
    logic              fetch_reg,    fetch_next;
    logic              stab_reg,     stab_next;
    logic [31:0]       mem_hold_reg, mem_hold_next;
    logic [31:0]       lvl_hold_reg, lvl_hold_next;
    logic [15:0]       gain_hold_reg [irs_pkg::NUM_CHAN];
    logic [15:0]       gain_hold_next [irs_pkg::NUM_CHAN];
    logic [4:0]        order_reg [irs_pkg::ORDER_DEPTH];
    logic [4:0]        order_next [irs_pkg::ORDER_DEPTH];
    logic              commit;
    logic [15:0]       indirect_write_location;
    irs_pkg::irs_kind_t ira_kind;
    irs_pkg::irs_kind_t new_kind;

    // Address and data are caught while the strobe is low, since the host
    // may release them before the synchronised strobe edge arrives.
    assign commit   = wr_prev_reg == 1'b0 && wr_s_n == 1'b1 && lat_ce_reg;
    assign indirect_write_location      = lat_d_reg;
    assign ira_kind = decode(ira_reg);
    assign new_kind = decode(lat_d_reg);

    always_comb begin
        wr_prev_next  = wr_s_n;
        lat_ce_next   = lat_ce_reg;
        lat_a_next    = lat_a_reg;
        lat_d_next    = lat_d_reg;
        wdat_lo_next  = wdat_lo_reg;
        wdat_hi_next  = wdat_hi_reg;
        ira_next      = ira_reg;
        sync_next     = 1'b0;
        fetch_next    = 1'b0;
        stab_next     = 1'b0;
        mem_hold_next = fetch_reg ? mem_rd_data : mem_hold_reg;
        lvl_hold_next = stab_reg ? level_acc_in : lvl_hold_reg;
        gain_hold_next = gain_hold_reg;
        order_next    = order_reg;
        if (!wr_s_n) begin
            lat_ce_next = !ce_s_n;
            lat_a_next  = addr_s;
            lat_d_next  = p_s;
        end
        if (commit) begin
            case (lat_a_reg)
                irs_pkg::DIR_DATA_LO: wdat_lo_next = lat_d_reg;
                irs_pkg::DIR_DATA_HI: wdat_hi_next = lat_d_reg;
                irs_pkg::DIR_RD_ADDR: begin
                    ira_next   = lat_d_reg; // RL6
                    fetch_next = new_kind == irs_pkg::K_MEM; // RL7
                    stab_next  = new_kind == irs_pkg::K_LEVEL; // RL7
                end
                irs_pkg::DIR_WR_ADDR: begin
                    if (indirect_write_location == irs_pkg::GLB_SYNC_STROBE) begin
                        sync_next = 1'b1; // RL1
                    end
                    if (indirect_write_location >= irs_pkg::GLB_ORDER_FIRST && indirect_write_location <= irs_pkg::GLB_ORDER_LAST) begin
                        order_next[indirect_write_location[4:0]] = wdat_lo_reg[4:0]; // RL3
                    end
                    if (indirect_write_location[11:0] == irs_pkg::OFS_GAIN) begin
                        // Broadcast nibble samples every channel on one edge
                        for (int c = 0; c < irs_pkg::NUM_CHAN; c++) begin
                            if (indirect_write_location[15:12] == irs_pkg::NIB_GLOBAL
                                || indirect_write_location[15:12] == 4'(c)) begin // RL10
                                gain_hold_next[c] = gain_loop_in[16*c +: 16]; // RL9
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            wr_prev_reg  <= 1'b1;
            lat_ce_reg   <= 1'b0;
            lat_a_reg    <= 3'h0;
            lat_d_reg    <= 16'h0000;
            wdat_lo_reg  <= 16'h0000;
            wdat_hi_reg  <= 16'h0000;
            ira_reg      <= 16'h0000;
            sync_reg     <= 1'b0;
            fetch_reg    <= 1'b0;
            stab_reg     <= 1'b0;
            mem_hold_reg <= 32'h00000000;
            lvl_hold_reg <= 32'h00000000;
            for (int c = 0; c < irs_pkg::NUM_CHAN; c++) begin
                gain_hold_reg[c] <= 16'h0000;
            end
            for (int k = 0; k < irs_pkg::ORDER_DEPTH; k++) begin
                order_reg[k] <= irs_pkg::ORDER_RESET;
            end
        end else begin
            wr_prev_reg   <= wr_prev_next;
            lat_ce_reg    <= lat_ce_next;
            lat_a_reg     <= lat_a_next;
            lat_d_reg     <= lat_d_next;
            wdat_lo_reg   <= wdat_lo_next;
            wdat_hi_reg   <= wdat_hi_next;
            ira_reg       <= ira_next;
            sync_reg      <= sync_next;
            fetch_reg     <= fetch_next;
            stab_reg      <= stab_next;
            mem_hold_reg  <= mem_hold_next;
            lvl_hold_reg  <= lvl_hold_next;
            gain_hold_reg <= gain_hold_next;
            order_reg     <= order_next;
        end
    end

    assign sync_out_pin   = sync_reg;
    assign mem_fetch_stb  = fetch_reg;
    assign level_stab_stb = stab_reg;
    assign mem_rd_addr    = ira_reg;

    // ------------------------------------------------------------
    // Readback word and host data bus
    // ------------------------------------------------------------
    logic [31:0] rd_word_reg, rd_word_next;
    logic [15:0] p_out_reg,   p_out_next;
    logic [1:0]  ira_ch;

    assign ira_ch = ira_reg[13:12];

    always_comb begin
        case (ira_kind)
            irs_pkg::K_CARRIER: rd_word_next = carrier_freq_in[32*ira_ch +: 32]; // RL8
            irs_pkg::K_TIMING:  rd_word_next = timing_freq_in[32*ira_ch +: 32]; // RL11
            irs_pkg::K_WAIT:    rd_word_next = wait_decr_in[32*ira_ch +: 32]; // RL11
            irs_pkg::K_GAIN:    rd_word_next = {16'h0000, gain_hold_reg[ira_ch]}; // RL9
            irs_pkg::K_MEM:     rd_word_next = mem_hold_reg; // RL12 RL13
            irs_pkg::K_LEVEL:   rd_word_next = lvl_hold_reg; // RL14
            irs_pkg::K_ORDER:   rd_word_next = {27'h0000000, order_reg[ira_reg[4:0]]};
            default:            rd_word_next = 32'h00000000; // RL10
        endcase
        case (addr_s)
            irs_pkg::DIR_DATA_LO: p_out_next = rd_word_reg[15:0]; // RL8
            irs_pkg::DIR_DATA_HI: p_out_next = rd_word_reg[31:16]; // RL8
            irs_pkg::DIR_RD_ADDR: p_out_next = ira_reg;
            default:              p_out_next = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rd_word_reg <= 32'h00000000;
            p_out_reg   <= 16'h0000;
        end else begin
            rd_word_reg <= rd_word_next;
            p_out_reg   <= p_out_next;
        end
    end

    assign p_out = p_out_reg;
    assign p_oe  = !ce_s_n && !rd_s_n;

    // ------------------------------------------------------------
    // FIFO read order sequencing
    // ------------------------------------------------------------
    logic [4:0]  fifo_idx_reg,  fifo_idx_next;
    logic [15:0] fifo_word_reg, fifo_word_next;
    logic [15:0] sel_word;

    irs_order_mux u_mux (
        .sel        (order_reg[fifo_idx_reg]),
        .i_data     (i_data),
        .q_data     (q_data),
        .mag_data   (mag_data),
        .phase_data (phase_data),
        .gain_data  (gain_loop_in),
        .word       (sel_word)
    );

    always_comb begin
        fifo_idx_next  = fifo_idx_reg;
        fifo_word_next = fifo_word_reg;
        if (fifo_rd_stb) begin
            fifo_word_next = sel_word; // RL4 RL5
            fifo_idx_next  = fifo_idx_reg + 5'h01; // RL3
        end
    end

    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            fifo_idx_reg  <= 5'h00;
            fifo_word_reg <= 16'h0000;
        end else begin
            fifo_idx_reg  <= fifo_idx_next;
            fifo_word_reg <= fifo_word_next;
        end
    end

    assign fifo_word = fifo_word_reg;

    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!core_rst_n);

    a_reset_release: // RL15
    assert property (disable iff (1'b0) $rose(rst_n) |-> !core_rst_n [*4] ##1 core_rst_n)
        else $error("internal reset not released on fourth edge");
    a_sync_on_write: // RL1
    assert property (commit && lat_a_reg == irs_pkg::DIR_WR_ADDR
                     && lat_d_reg == irs_pkg::GLB_SYNC_STROBE |=> sync_out_pin ##1 !sync_out_pin)
        else $error("sync strobe write gave no one-clock pulse");
    a_sync_cause: // RL1
    assert property ($rose(sync_out_pin) |-> $past(commit && lat_a_reg == irs_pkg::DIR_WR_ADDR))
        else $error("sync pulse without a strobe write");
    a_fetch_on_write: // RL7
    assert property (commit && lat_a_reg == irs_pkg::DIR_RD_ADDR && new_kind == irs_pkg::K_MEM
                     |=> mem_fetch_stb ##1 (!mem_fetch_stb && mem_hold_reg == $past(mem_rd_data)))
        else $error("memory address write gave no fetch");
    a_live_no_strobe: // RL8
    assert property (commit && lat_a_reg == irs_pkg::DIR_RD_ADDR && new_kind == irs_pkg::K_CARRIER
                     |=> !mem_fetch_stb && !level_stab_stb)
        else $error("strobe issued for a live source");
    a_live_follow: // RL8
    assert property (ira_kind == irs_pkg::K_CARRIER && !commit
                     |=> rd_word_reg == $past(carrier_freq_in[32*ira_ch +: 32]))
        else $error("live source not followed");
    a_gain_sample: // RL9
    assert property (commit && lat_a_reg == irs_pkg::DIR_WR_ADDR && indirect_write_location == 16'hF00F
                     |=> gain_hold_reg[3] == $past(gain_loop_in[63:48]))
        else $error("broadcast gain sample missed channel 3");
    a_level_hold: // RL14
    assert property (level_stab_stb |=> lvl_hold_reg == $past(level_acc_in))
        else $error("level detector value not captured");
    a_bad_nibble: // RL10
    assert property (ira_reg[15:12] > irs_pkg::NIB_LAST_CHAN && ira_reg[15:12] < irs_pkg::NIB_GLOBAL
                     |=> rd_word_reg == 32'h00000000)
        else $error("invalid channel nibble returned data");
    a_order_store: // RL3
    assert property (commit && lat_a_reg == irs_pkg::DIR_WR_ADDR && indirect_write_location == irs_pkg::GLB_ORDER_FIRST
                     |=> order_reg[0] == $past(wdat_lo_reg[4:0]))
        else $error("read order location not stored");
    a_order_i_low: // RL4
    assert property (fifo_rd_stb && order_reg[fifo_idx_reg][2:0] == irs_pkg::TYPE_I_LO
                     |=> fifo_word_reg
                         == {$past(i_data[24*order_reg[fifo_idx_reg][4:3] +: 8]), 8'h00})
        else $error("I low type not padded");

    c_sync_pulse: cover property (sync_out_pin);
    c_mem_fetch:  cover property (mem_fetch_stb ##[1:20] p_oe);
    c_gain_read:  cover property (ira_kind == irs_pkg::K_GAIN && p_oe);
    c_fifo_wrap:  cover property (fifo_rd_stb && fifo_idx_reg == 5'h1F);

endmodule // irs_host_port

// [testbench/irs_host_model.sv]
// Microprocessor model that drives the parallel host port
module irs_host_model (
    input  wire logic        ref_clk,
    output logic             ce_n,
    output logic             wr_n,
    output logic             rd_n,
    output logic [2:0]       addr,
    output logic [15:0]      p_in,
    input  wire logic [15:0] p_out,
    output logic             rd_done,
    output logic [15:0]      rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {ce_n, wr_n, rd_n, rd_done, addr} = 7'h70;
        p_in = 16'hA5A5;
        rd_data = 16'h0000;
    end

    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    // Four clocks low and four high, so the pin synchroniser sees both levels
    task automatic write(logic [2:0] a, logic [15:0] d);
        {ce_n, wr_n, addr, p_in} = {2'b00, a, d};
        step(4);
        wr_n = 1'b1;
        step(4);
        ce_n = 1'b1;
        // A released bus does not keep its last value
        p_in = ~d;
        // Let an edge pass so a following call never redrives ce_n in this step
        step(1);
    endtask

    // Strobed sources refresh only here, so every fresh sample calls it again
    task automatic select(logic [15:0] indirect_read_location);
        write(3'h3, indirect_read_location);
    endtask

    task automatic read(logic [2:0] a);
        {ce_n, rd_n, addr} = {2'b00, a};
        step(6);
        {rd_done, rd_data} = {1'b1, p_out};
        step(1);
        {ce_n, rd_n, rd_done} = 3'b110;
        step(3);
    endtask
endmodule // irs_host_model

// [testbench/testbench.sv]
// Self-checking testbench of the host port readback block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic [127:0] carrier_freq_in, timing_freq_in, wait_decr_in;
    logic [95:0]  i_data, q_data, mag_data;
    logic [63:0]  gain_loop_in, phase_data, gain_smp;
    logic [31:0]  level_acc_in, mem_rd_data;
    logic [15:0]  p_in, p_out, mem_rd_addr, fifo_word, rd_data;
    logic [15:0]  exp_q[$];
    logic [4:0]   sels[8];
    logic [2:0]   addr;
    logic [1:0]   sync_pipe = 2'h0;
    logic         ce_n, wr_n, rd_n, p_oe, sync_out_pin, level_stab_stb, mem_fetch_stb, rd_done;
    logic         ref_clk = 1'b0, rst_n = 1'b0, fifo_rd_stb = 1'b0, fifo_seen = 1'b0;
    int           errors = 0, tests_run = 0, sync_hi = 0, fetch_hi = 0, stab_hi = 0;

    always #50 ref_clk = ~ref_clk;

    irs_host_port u_irs_host_port (.ref_clk, .rst_n, .ce_n, .wr_n, .rd_n, .addr, .p_in,
        .p_out, .p_oe, .sync_out_pin, .carrier_freq_in, .timing_freq_in, .wait_decr_in,
        .gain_loop_in, .level_acc_in, .level_stab_stb, .mem_rd_addr, .mem_fetch_stb,
        .mem_rd_data, .i_data, .q_data, .mag_data, .phase_data, .fifo_rd_stb, .fifo_word);
    irs_host_model u_irs_host_model (.ref_clk, .ce_n, .wr_n, .rd_n, .addr, .p_in, .p_out,
        .rd_done, .rd_data);

    task automatic chk(logic [31:0] seen, logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [15:0] sel_word(logic [4:0] s);
        int          c;
        logic [23:0] v;
        c = s[4:3];
        v = (s[2:1] == 2'd0) ? i_data[24*c+:24] :
            (s[2:1] == 2'd1) ? q_data[24*c+:24] : mag_data[24*c+:24];
        if (s[2:1] == 2'd3)
            return s[0] ? gain_loop_in[16*c+:16] : phase_data[16*c+:16];
        return s[0] ? {v[7:0], 8'h00} : v[23:8];
    endfunction

    task automatic rd32(logic [15:0] indirect_read_location, logic [31:0] want);
        u_irs_host_model.select(indirect_read_location);
        exp_q.push_back(want[15:0]);
        u_irs_host_model.read(3'h0);
        exp_q.push_back(want[31:16]);
        u_irs_host_model.read(3'h1);
    endtask

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge ref_clk) fifo_seen <= fifo_rd_stb;
    // Sync-out reaches a far part's sync-in through two pipeline stages
    always @(posedge ref_clk) sync_pipe <= {sync_pipe[0], sync_out_pin};
    always @(negedge ref_clk) begin
        if (sync_pipe[1]) sync_hi++;
        if (mem_fetch_stb) fetch_hi++;
        if (level_stab_stb) stab_hi++;
        if (rd_done) chk(rd_data, exp_q.pop_front());
        if (rd_done) chk(p_oe, 1'b1);
        if (fifo_seen) chk(fifo_word, exp_q.pop_front());
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hD8F084C5));
        for (int k = 0; k < 4; k++) begin
            {carrier_freq_in[32*k+:32], timing_freq_in[32*k+:32]} = {$urandom, $urandom};
            {wait_decr_in[32*k+:32], gain_loop_in[16*k+:16]} = {$urandom, 16'($urandom)};
            {i_data[24*k+:24], q_data[24*k+:24]} = {24'($urandom), 24'($urandom)};
            {mag_data[24*k+:24], phase_data[16*k+:16]} = {24'($urandom), 16'($urandom)};
        end
        {level_acc_in, mem_rd_data} = {$urandom, $urandom};
        repeat (16) @(posedge ref_clk);
        #10 rst_n = 1'b1;
        u_irs_host_model.step(6);
        // Two sync writes of location F809, one pulse each
        repeat (2) u_irs_host_model.write(3'h2, 16'hF809);
        u_irs_host_model.step(6);
        chk(sync_hi, 2);
        u_irs_host_model.write(3'h2, 16'hF00F);
        for (int k = 0; k < 8; k++) begin
            sels[k] = {2'($urandom), 3'(k)};
            u_irs_host_model.write(3'h0, {11'h000, sels[k]});
            u_irs_host_model.write(3'h2, 16'hF820 + 16'(k));
        end
        fifo_rd_stb = 1'b1;
        for (int k = 0; k < 8; k++) begin
            exp_q.push_back(sel_word(sels[k]));
            u_irs_host_model.step(1);
        end
        fifo_rd_stb = 1'b0;
        // The sampled gain must not follow the live value
        {gain_smp, gain_loop_in} = {gain_loop_in, $urandom, $urandom};
        rd32(16'h200F, {16'h0000, gain_smp[47:32]});
        rd32(16'hF823, {27'h0, sels[3]});
        rd32(16'h2006, carrier_freq_in[64+:32]);
        carrier_freq_in[79:64] = ~carrier_freq_in[79:64];
        exp_q.push_back(carrier_freq_in[79:64]);
        u_irs_host_model.read(3'h0);
        timing_freq_in[96+:32] = $urandom;
        rd32(16'h3009, timing_freq_in[96+:32]);
        wait_decr_in[31:0] = $urandom;
        rd32(16'h000C, wait_decr_in[31:0]);
        level_acc_in = $urandom;
        rd32(16'hF806, level_acc_in);
        rd32(16'h117F, mem_rd_data);
        chk(mem_rd_addr, 16'h117F);
        mem_rd_data = $urandom;
        rd32(16'h35FF, mem_rd_data);
        rd32(16'h500C, 32'h0);
        u_irs_host_model.step(4);
        chk(exp_q.size(), 0);
        chk(fetch_hi, 2);
        chk(stab_hi, 1);
        chk(p_oe, 1'b0);
        stop_test();
    end
endmodule // testbench
